/* File: design/ctw_ctrl.sv */
// can transceiver digital control: modes, driver mapping, receive path,
// slew select, sleep termination and bus wake-up detection
// assumes bus comparator outputs are synchronous to sys_clk
//
// Function
// - in normal mode the driver and receiver are on, transmit controls the bus, rx reports it, split active.
// - in receive-only mode the driver is off, transmit is ignored and rx still reports the bus.
// - the driver is enabled only in normal mode once the transmit input has been seen high.
// - with the driver on, transmit high gives recessive and transmit low gives dominant.
// - rx is high when the differential voltage is below threshold and low when above.
// - three slew rates are selectable, fastest by default, applied to both edge directions.
// - in sleep both drivers are off, lines go to ground and split is high impedance.
// - a bus wake-up sets a readable flag, pulses the interrupt and wakes a low-power device.
// - returning to normal from sleep restores the lines to recessive.
// - bus wake-up detection in sleep acts only when enabled.
// - with single-pulse select low, wake needs three valid dominant pulses; short pulses between them are ignored.
// - with single-pulse select high, one dominant pulse of 2.0 us wakes.
// - a valid pulse lasts over 500 ns and three must fall within 120 us.
// - a permanent recessive rx fault sets a flag and forces receive-only mode.
`timescale 1ns/10ps
module ctw_ctrl
  import ctw_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic [1:0] modeSel, // requested mode, ctw_mode_e coding
  input wire logic [1:0] slewSel, // slew rate select from spi
  input wire logic slewWr, // strobe loading slewSel
  input wire logic wakeEn, // bus wake-up enable
  input wire logic single_pulse_wake_sel, // one-pulse wake select
  input wire logic lowPower, // device in a low-power mode
  input wire logic txIn, // transmit input from controller
  input wire logic busDom, // differential comparator: 1 = dominant
  input wire logic wakeDom, // wake-up receiver: 1 = dominant
  input wire logic rxSense, // sensed level of the rx pin
  input wire logic wakeFlagClr, // clear wake flag
  input wire logic rxFaultClr, // spare clear of rx fault flag
  input wire logic rxReady, // consumer accepts rx sample
  output ctw_drv_s drv, // analog front-end control
  output logic rxOut, // receive output pin level
  output logic rxValid, // rx sample available
  output logic rxBufReady, // buffer accepting samples
  output logic wakeFlag, // bus wake-up flag
  output logic wakeIrq, // one-cycle interrupt pulse
  output logic wakeReq, // wake request to device mode logic
  output logic rxFault // rx permanent recessive flag
);
  localparam logic [14:0] WIN_C = 15'(WIN_CYC);
  localparam logic [14:0] PMIN_C = 15'(PULSE_MIN_CYC + 1);
  localparam logic [14:0] SGL_C = 15'(SINGLE_CYC);

  typedef enum logic [1:0] {
    WK_IDLE = 2'b00,
    WK_PULSE = 2'b01,
    WK_GAP = 2'b10
  } ctw_wk_e;

  ctw_mode_e mode;
  logic txArmed_reg, txArmed_next;
  logic [1:0] slew_reg, slew_next;
  logic rxFault_reg, rxFault_next;
  logic wakeFlag_reg, wakeFlag_next;
  logic irq_reg, irq_next;
  logic busDomD_reg;
  logic rxOut_reg;
  ctw_wk_e wk_reg, wk_next;
  logic [14:0] pulseCnt_reg, pulseCnt_next;
  logic [14:0] winCnt_reg, winCnt_next;
  logic [1:0] nPulse_reg, nPulse_next;
  logic effNormal, wakeHit, sleeping, rxBit;

  // rx fault overrides a normal request
  always_comb
  begin
    case (modeSel)
      2'b01: mode = rxFault_reg ? CTW_RXONLY : CTW_NORMAL;
      2'b10: mode = CTW_RXONLY;
      default: mode = CTW_SLEEP;
    endcase
  end
  assign effNormal = (mode == CTW_NORMAL);
  assign sleeping = (mode == CTW_SLEEP);

  // driver arming and slew register; arming drops whenever normal mode is left
  always_comb
  begin
    txArmed_next = txArmed_reg;
    if (!effNormal)
    begin
      txArmed_next = 1'b0;
    end
    else if (txIn)
    begin
      txArmed_next = 1'b1;
    end
    slew_next = slewWr ? slewSel : slew_reg;
  end

  // front-end mapping; slew applies to both transitions in the analog stage
  always_comb
  begin
    drv.drvEn = effNormal && txArmed_reg;
    drv.dominant = effNormal && txArmed_reg && !txIn;
    drv.rxEn = !sleeping;
    drv.splitEn = !sleeping;
    drv.gndTerm = sleeping;
    drv.slew = slew_reg;
  end

  // rx level: recessive reads high; sleeping reports recessive
  assign rxBit = sleeping ? 1'b1 : !busDom;

  // rx fault: as the bus returns to recessive the pin still carries the dominant low,
  // so a high sense there means the pin is stuck recessive; comparing against the
  // driven level avoids a false fault on the first cycle after sleep
  // recovery by sampling low on the transmit input; a new fault wins over a clear
  always_comb
  begin
    rxFault_next = rxFault_reg;
    if (!sleeping && busDomD_reg && !busDom && rxSense && !rxOut_reg)
    begin
      rxFault_next = 1'b1;
    end
    else if (rxFaultClr || (rxFault_reg && !txIn))
    begin
      rxFault_next = 1'b0;
    end
  end

  // wake-up pattern detector, runs only in sleep with wake enabled
  always_comb
  begin
    wk_next = wk_reg;
    pulseCnt_next = pulseCnt_reg;
    winCnt_next = winCnt_reg;
    nPulse_next = nPulse_reg;
    wakeHit = 1'b0;
    if (!(sleeping && wakeEn))
    begin
      wk_next = WK_IDLE;
      nPulse_next = 2'h0;
      pulseCnt_next = 15'h0;
      winCnt_next = 15'h0;
    end
    else
    begin
      if (wk_reg != WK_IDLE)
      begin
        winCnt_next = winCnt_reg + 15'h1;
      end
      case (wk_reg)
        WK_IDLE:
        begin
          nPulse_next = 2'h0;
          winCnt_next = 15'h0;
          pulseCnt_next = 15'h0;
          if (wakeDom)
          begin
            wk_next = WK_PULSE;
            pulseCnt_next = 15'h1;
          end
        end
        WK_PULSE:
        begin
          pulseCnt_next = pulseCnt_reg + 15'h1;
          if (single_pulse_wake_sel && pulseCnt_reg >= SGL_C)
          begin
            wakeHit = 1'b1;
            wk_next = WK_IDLE;
          end
          else if (!wakeDom)
          begin
            if (pulseCnt_reg >= PMIN_C)
            begin
              nPulse_next = nPulse_reg + 2'h1;
              if (!single_pulse_wake_sel && nPulse_reg == 2'(PAT_PULSES - 1))
              begin
                wakeHit = 1'b1;
                wk_next = WK_IDLE;
              end
              else
              begin
                wk_next = WK_GAP;
              end
            end
            else
            begin
              wk_next = (nPulse_reg == 2'h0) ? WK_IDLE : WK_GAP;
            end
          end
        end
        WK_GAP:
        begin
          if (wakeDom)
          begin
            wk_next = WK_PULSE;
            pulseCnt_next = 15'h1;
          end
        end
        default: wk_next = WK_IDLE;
      endcase
      // window expiry discards partial pattern
      if (wk_reg != WK_IDLE && !wakeHit && winCnt_reg >= WIN_C)
      begin
        wk_next = WK_IDLE;
        nPulse_next = 2'h0;
      end
    end
    // set wins over clear
    wakeFlag_next = wakeHit ? 1'b1 : (wakeFlagClr ? 1'b0 : wakeFlag_reg);
    irq_next = wakeHit;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      txArmed_reg <= 1'b0;
      slew_reg <= SLEW_RESET;
      rxFault_reg <= 1'b0;
      wakeFlag_reg <= 1'b0;
      irq_reg <= 1'b0;
      busDomD_reg <= 1'b0;
      rxOut_reg <= RXD_RESET;
      wk_reg <= WK_IDLE;
      pulseCnt_reg <= 15'h0;
      winCnt_reg <= 15'h0;
      nPulse_reg <= 2'h0;
    end
    else
    begin
      txArmed_reg <= txArmed_next;
      slew_reg <= slew_next;
      rxFault_reg <= rxFault_next;
      wakeFlag_reg <= wakeFlag_next;
      irq_reg <= irq_next;
      busDomD_reg <= busDom;
      rxOut_reg <= rxBit;
      wk_reg <= wk_next;
      pulseCnt_reg <= pulseCnt_next;
      winCnt_reg <= winCnt_next;
      nPulse_reg <= nPulse_next;
    end
  end

  // registered pin level and status flags
  assign rxOut = rxOut_reg;
  assign wakeFlag = wakeFlag_reg;
  assign wakeIrq = irq_reg;
  assign wakeReq = irq_reg && lowPower;
  assign rxFault = rxFault_reg;

  // sample stream toward the controller side; samples offered while the buffer is full are dropped
  ctw_buf2 u_buf
  (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .inValid(!sleeping),
    .inReady(rxBufReady),
    .inData(rxBit),
    .outValid(rxValid),
    .outReady(rxReady),
    .outData()
  );
endmodule

/* File: design/ctw_pkg.sv */
// package for the can transceiver mode and wake-up control block
// assumes a 100 MHz system clock; bus levels arrive as digital comparator outputs
package ctw_pkg;
  localparam int CLK_MHZ = 100;
  // valid dominant pulse: longer than 500 ns (least time, round up)
  localparam int PULSE_MIN_NS = 500;
  localparam int PULSE_MIN_CYC = (PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
  // single-pulse wake length 2.0 us (2000 ns)
  localparam int SINGLE_NS = 2000;
  localparam int SINGLE_CYC = (SINGLE_NS * CLK_MHZ + 999) / 1000;
  // pattern window 120 us (longest time, round down)
  localparam int WIN_US = 120;
  localparam int WIN_CYC = WIN_US * CLK_MHZ;
  localparam int PAT_PULSES = 3;
  localparam logic [1:0] SLEW_RESET = 2'h0; // fastest rate
  localparam logic RXD_RESET = 1'b1;
  // interface modes
  typedef enum logic [1:0] {
    CTW_SLEEP = 2'b00,
    CTW_NORMAL = 2'b01,
    CTW_RXONLY = 2'b10
  } ctw_mode_e;
  // drive commands to the analog front end
  typedef struct packed {
    logic drvEn;     // bus driver enabled
    logic dominant;  // driver in dominant state
    logic rxEn;      // differential receiver enabled
    logic splitEn;   // split bias active, else high impedance
    logic gndTerm;   // input resistors switched to ground
    logic [1:0] slew; // selected slew rate
  } ctw_drv_s;
endpackage

/* File: design/ctw_buf2.sv */
// two-entry valid/ready buffer for received bus samples
// assumes one clock, synchronous active-high reset
`timescale 1ns/10ps
module ctw_buf2
  import ctw_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic inValid, // sample offered
  output logic inReady, // space available
  input wire logic inData, // sample bit
  output logic outValid, // sample available
  input wire logic outReady, // consumer takes sample
  output logic outData // head sample, registered
);
  logic [1:0] mem_reg, mem_next;
  logic [1:0] cnt_reg, cnt_next;
  logic push, pop;

  // handshake terms
  assign inReady = (cnt_reg != 2'h2);
  assign outValid = (cnt_reg != 2'h0);
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem_reg[0];

  // shift-out storage; head always in slot 0
  always_comb
  begin
    mem_next = mem_reg;
    cnt_next = cnt_reg;
    if (pop)
    begin
      mem_next[0] = mem_reg[1];
    end
    if (push)
    begin
      mem_next[(pop ? cnt_reg - 2'h1 : cnt_reg) == 2'h1 ? 1'b1 : 1'b0] = inData;
    end
    cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      mem_reg <= {2{RXD_RESET}};
      cnt_reg <= 2'h0;
    end
    else
    begin
      mem_reg <= mem_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule

/* File: bench/ctw_ctrl_asserts.sv */
// port checker for ctw_ctrl
// assumes a single 100 MHz domain and the bind at the foot of this file
`timescale 1ns/10ps
module ctw_ctrl_asserts
  import ctw_pkg::*;
(
  input wire logic sys_clk, // clock
  input wire logic sys_rst, // reset
  input wire logic [1:0] modeSel, // mode
  input wire logic [1:0] slewSel, // slew code
  input wire logic slewWr, // slew load
  input wire logic wakeEn, // wake enable
  input wire logic single_pulse_wake_sel, // one-pulse wake
  input wire logic lowPower, // low power
  input wire logic txIn, // transmit
  input wire logic busDom, // bus level
  input wire logic wakeDom, // wake receiver
  input ctw_drv_s drv, // front end
  input wire logic rxOut, // rx pin
  input wire logic wakeFlag, // wake flag
  input wire logic wakeIrq, // wake pulse
  input wire logic wakeReq, // wake request
  input wire logic rxFault // rx fault
);
  logic domPrev;
  logic [15:0] runLen;
  logic [15:0] runNext;
  // length of the latest wake-receiver dominant run, held once it ends
  always_comb
  begin
    runNext = runLen;
    if (wakeDom)
      runNext = !domPrev ? 16'h1 : (runLen == 16'hffff) ? runLen : runLen + 16'h1;
  end
  always_ff @(posedge sys_clk)
  begin
    domPrev <= sys_rst ? 1'b0 : wakeDom;
    runLen <= sys_rst ? 16'h0 : runNext;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // irq comes with the flag, a gated request and lasts one cycle only
  sequence s_flagged;
    wakeFlag && wakeReq == lowPower ##1 !wakeIrq;
  endsequence
  property p_norm; modeSel == 2'h1 && !rxFault |-> drv.rxEn && drv.splitEn && !drv.gndTerm; endproperty
  a_norm: assert property (p_norm) else $error("normal mode front end wrong");
  property p_rxOnly;
    modeSel == 2'h2 || (modeSel == 2'h1 && rxFault) |-> !drv.drvEn && drv.rxEn;
  endproperty
  a_rxOnly: assert property (p_rxOnly) else $error("driver on in receive-only");
  property p_drvEn; drv.drvEn |-> modeSel == 2'h1 && !rxFault; endproperty
  a_drvEn: assert property (p_drvEn) else $error("driver on outside normal");
  property p_dom; drv.drvEn |-> drv.dominant == !txIn; endproperty
  a_dom: assert property (p_dom) else $error("driver state not from transmit");
  property p_rx; $past(modeSel[1] ^ modeSel[0]) |-> rxOut == !$past(busDom); endproperty
  a_rx: assert property (p_rx) else $error("rx level not inverse of bus");
  property p_slew; ##1 drv.slew == ($past(slewWr) ? $past(slewSel) : $past(drv.slew)); endproperty
  a_slew: assert property (p_slew) else $error("slew code not loaded or held");
  property p_sleep; modeSel[1] == modeSel[0] |-> !drv.drvEn && drv.gndTerm && !drv.splitEn; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep termination wrong");
  property p_irq; wakeIrq |-> s_flagged; endproperty
  a_irq: assert property (p_irq) else $error("wake pulse without flag");
  property p_wakeEn; $rose(wakeIrq) |-> $past(wakeEn && modeSel[1] == modeSel[0]); endproperty
  a_wakeEn: assert property (p_wakeEn) else $error("wake while detection off");
  property p_run; $rose(wakeIrq) |-> runLen > 16'(PULSE_MIN_CYC); endproperty
  a_run: assert property (p_run) else $error("wake after too short a pulse");
endmodule
bind ctw_ctrl ctw_ctrl_asserts i_chk (.sys_clk, .sys_rst, .modeSel, .slewSel, .slewWr, .wakeEn,
  .single_pulse_wake_sel, .lowPower, .txIn, .busDom, .wakeDom, .drv, .rxOut, .wakeFlag,
  .wakeIrq, .wakeReq, .rxFault);

/* File: bench/ctw_bus_model.sv */
// bus and rx pin model standing at the far side of ctw_ctrl
// assumes the comparator sees the driver at once, no analog delay
`timescale 1ns/10ps
module ctw_bus_model
  import ctw_pkg::*;
(
  input ctw_drv_s drv, // front-end control
  input wire logic extDom, // another node drives dominant
  input wire logic rxOut, // rx pin as driven
  input wire logic rxShort, // rx pin shorted high
  output logic busDom, // differential comparator
  output logic rxSense // sensed rx pin
);
  // wired bus: any dominant driver wins
  assign busDom = (drv.drvEn & drv.dominant) | extDom;
  // a short to the supply hides the driven low level
  assign rxSense = rxOut | rxShort;
endmodule

/* File: bench/ctw_ctrl_tb.sv */
// self-checking bench for ctw_ctrl
// assumes ctw_bus_model stands for the bus and the rx pin wiring
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); mismatches++; end end
module ctw_ctrl_tb
  import ctw_pkg::*;
;
  logic sys_clk = 0, sys_rst = 1, slewWr = 0, wakeEn = 0, single_pulse_wake_sel = 0;
  logic lowPower = 1, txIn = 1, wakeDom = 0, wakeFlagClr = 0, rxFaultClr = 0, rxReady = 1;
  logic extDom = 0, rxShort = 0, busDom, rxSense, rxOut, rxValid, rxBufReady;
  logic wakeFlag, wakeIrq, wakeReq, rxFault;
  logic [1:0] modeSel = 2'h0, slewSel = 2'h0;
  ctw_drv_s drv;
  int mismatches = 0, samples_checked = 0, cyc = 0, irqs = 0, reqs = 0;
  ctw_bus_model i_bus (.drv, .extDom, .rxOut, .rxShort, .busDom, .rxSense);
  ctw_ctrl i_dut (.sys_clk, .sys_rst, .modeSel, .slewSel, .slewWr, .wakeEn,
    .single_pulse_wake_sel, .lowPower, .txIn, .busDom, .wakeDom, .rxSense, .wakeFlagClr,
    .rxFaultClr, .rxReady, .drv, .rxOut, .rxValid, .rxBufReady, .wakeFlag, .wakeIrq,
    .wakeReq, .rxFault);
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  // count wake pulses; the ceiling is well above the longest wait
  always @(posedge sys_clk)
  begin
    cyc++;
    if (wakeIrq === 1'b1) irqs++;
    if (wakeReq === 1'b1) reqs++;
    if (cyc == 40000)
    begin
      mismatches++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic step(int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic pulse(int hi, int lo);
    wakeDom = 1;
    step(hi);
    wakeDom = 0;
    step(lo);
  endtask
  // rx pin level expected from what the bus carries
  function automatic logic expRx(logic tx, logic ext, logic drvOn);
    return !((drvOn & !tx) | ext);
  endfunction
  initial
  begin
    void'($urandom(49));
    step(2);
    sys_rst = 0;
    `CHK("slew rst", 2'h0, drv.slew)
    modeSel = 2'h1;
    step(2);
    `CHK("drvEn", 1'b1, drv.drvEn)
    // two-cycle bits stay far above the lowest allowed baud rate
    for (int m = 1; m < 3; m++)
    begin
      modeSel = 2'(m);
      repeat (40)
      begin
        txIn = 1'($urandom);
        extDom = 1'($urandom);
        step();
        `CHK("dom", (m == 1) & !txIn, drv.dominant & drv.drvEn)
        step();
        `CHK("rx", expRx(txIn, extDom, m == 1), rxOut)
      end
      $display("mode %0d done", m);
    end
    modeSel = 2'h1;
    txIn = 1;
    extDom = 0;
    step(2);
    // first pass clears by the spare strobe, second by a low transmit sample
    for (int c = 0; c < 2; c++)
    begin
      rxShort = 1;
      extDom = 1;
      step(3);
      extDom = 0;
      step(2);
      `CHK("fault", 2'h2, {rxFault, drv.drvEn})
      rxShort = 0;
      rxFaultClr = (c == 0);
      txIn = (c == 0);
      step(2);
      rxFaultClr = 0;
      `CHK("fault clr", 1'b0, rxFault)
      `CHK("drv wait", 1'(c == 0), drv.drvEn)
    end
    txIn = 1;
    for (int s = 0; s < 3; s++)
    begin
      slewSel = 2'(2 - s);
      slewWr = 1;
      step();
      slewWr = 0;
      step();
      `CHK("slew", 2'(2 - s), drv.slew)
    end
    // stalled consumer: two entries fill, then the buffer refuses
    rxReady = 0;
    repeat (4)
    begin
      extDom = ~extDom;
      step();
    end
    `CHK("buf full", 2'h2, {rxValid, rxBufReady})
    rxReady = 1;
    step(4);
    `CHK("buf drain", 1'b1, rxBufReady)
    $display("path tests done");
    modeSel = 2'h3;
    step(2);
    `CHK("sleep", 4'h3, {drv.drvEn, drv.splitEn, drv.gndTerm, rxOut})
    modeSel = 2'h0;
    repeat (3) pulse(PULSE_MIN_CYC + 2 + $urandom % 20, 60);
    `CHK("wake off", 1'b0, wakeFlag)
    wakeEn = 1;
    pulse(60, 60);
    pulse(60, WIN_CYC);
    pulse(60, 60);
    `CHK("expired", 0, irqs)
    pulse(PULSE_MIN_CYC + 2, 60);
    pulse(60, 60);
    `CHK("pattern", 3'h7, {wakeFlag, irqs == 1, reqs == 1})
    wakeFlagClr = 1;
    step();
    wakeFlagClr = 0;
    repeat (3) pulse(PULSE_MIN_CYC - 5, 60);
    `CHK("short", 1'b0, wakeFlag)
    single_pulse_wake_sel = 1;
    lowPower = 0;
    pulse(SINGLE_CYC / 2, 60);
    `CHK("half", 1'b0, wakeFlag)
    pulse(SINGLE_CYC + 20, 60);
    `CHK("single", 3'h7, {wakeFlag, irqs == 2, reqs == 1})
    $display("wake tests done");
    modeSel = 2'h1;
    step(2);
    `CHK("back", 3'h6, {drv.drvEn, drv.splitEn, drv.dominant})
    end_sim();
  end
endmodule
